/* inc/urs_pkg.sv */
/*
 * Constants for the UART register and status block: register offsets,
 * status and control bit positions, reset values and the underrun answer.
 * Assumes a 16-bit register bus with word offsets, as used by urs_top.
 */
package urs_pkg;

    // ------------------------------------------------------------------
    // Register word offsets
    // ------------------------------------------------------------------
    localparam logic [2:0] URS_OFF_RX_DATA = 3'h0;
    localparam logic [2:0] URS_OFF_TX_DATA = 3'h1;
    localparam logic [2:0] URS_OFF_STATUS = 3'h2;
    localparam logic [2:0] URS_OFF_ENABLES = 3'h3;
    localparam logic [2:0] URS_OFF_DIVIDER = 3'h4;
    localparam logic [2:0] URS_OFF_PKEND = 3'h5;
    localparam logic [2:0] URS_OFF_RX_FILL = 3'h6;
    localparam logic [2:0] URS_OFF_TX_FILL = 3'h7;

    localparam int URS_REG_W = 16;

    // ------------------------------------------------------------------
    // Status bit positions (control enables share them)
    // ------------------------------------------------------------------
    localparam int URS_ST_RX_NEAR = 15;
    localparam int URS_ST_RX_FULL = 14;
    localparam int URS_ST_UNDR = 13;
    localparam int URS_ST_PKEND = 12;
    localparam int URS_ST_CTS = 11;
    localparam int URS_ST_CTSC = 10;
    localparam int URS_ST_EXC = 8;
    localparam int URS_ST_RXAV = 7;
    localparam int URS_ST_TXSP = 6;
    localparam int URS_ST_TXIDLE = 5;
    localparam int URS_ST_TXOV = 4;
    localparam int URS_ST_RXOV = 3;
    localparam int URS_ST_LBREAK = 2;
    localparam int URS_ST_FRAME = 1;
    localparam int URS_ST_PARITY = 0;

    // Control bits that are not interrupt enables
    localparam int URS_CT_RTS = 11;
    localparam int URS_CT_TXBREAK = 9;
    localparam logic [15:0] URS_CT_IRQ_MASK = 16'hF5FF;

    // ------------------------------------------------------------------
    // Reset values and fixed answers
    // ------------------------------------------------------------------
    localparam logic [15:0] URS_ENABLES_RST = 16'h0000;
    localparam logic [15:0] URS_PKEND_RST = 16'h0000;
    localparam logic [15:0] URS_DIVIDER_RST = 16'h0000;
    localparam logic [15:0] URS_UNDR_DATA = 16'h000F;
    localparam logic [15:0] URS_ZERO16 = 16'h0000;

endpackage : urs_pkg

/* hw/urs_top.sv */
/*
 * UART register and status block with a receive and a transmit FIFO,
 * plus the parameterised FIFO it uses.
 * Assumes a host on a simple 16-bit register port (one word per offset,
 * registered read data one cycle after the read strobe) and a serial
 * shifter on the same clock that offers received characters and error
 * pulses and drains transmit characters by valid/ready.
 */
// Functional notes
// RULE1: Decode eight word offsets from receive data 0x0 to transmit fill 0x7.
// RULE2: Divider register at 0x4 exists only when the baud rate is not fixed.
// RULE3: Transmit data port is write-only; low bits queue in the transmit FIFO.
// RULE4: Receive data port is read-only; returns the oldest received word.
// RULE5: Status reads are always allowed and change no status bit.
// RULE6: Writing zero to status clears the sticky error and change flags.
// RULE7: Bit 15 nearly full at configurable free margin; bit 14 full.
// RULE8: Reading an empty receive FIFO sets bit 13 and returns 0x0F.
// RULE9: With the packet-end option, bit 12 sets on the configured character.
// RULE10: Packet-end character register and its flag exist only with that option.
// RULE11: With flow control, bit 11 shows the clear-to-send input level.
// RULE12: With flow control, bit 10 sets on any clear-to-send change and holds.
// RULE13: Bit 8 is the OR of the error flags and is not writable.
// RULE14: Bit 7 is one while the receive FIFO holds a word.
// RULE15: Bit 6 is one while the transmit FIFO has free space.
// RULE16: Bit 5 is one only when transmit FIFO and shifter are both empty.
// RULE17: Writes to a full transmit FIFO are dropped and set bit 4.
// RULE18: A character arriving at a full receive FIFO is dropped, setting bit 3.
// RULE19: Sticky break bit 2, framing bit 1, parity bit 0; bit 9 reserved.
// RULE20: Interrupt is high while any status bit and its enable are both one; the code masks enable bit 11, so CTS level never interrupts.
// RULE21: Reset clears every interrupt enable.
// RULE22: Interrupt conditions stay set until the host clears status; the code keeps bits 15, 14, 7, 6 and 5 live, following the FIFOs.
// RULE23: Reserved bits read zero and writes to them are ignored.
`timescale 1ns/1ps
`default_nettype none

module urs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level
);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count_r != FULL_LEVEL);
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign level = count_r;
    assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

    // Explicit wrap keeps non-power-of-two depths legal
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == LAST_PTR) ? '0 : p + AW'(1);
    endfunction : ptr_inc

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= ptr_inc(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= ptr_inc(rd_ptr_r);
            end
            count_r <= count_nxt;
        end
    end
endmodule : urs_fifo

module urs_top #(
    parameter int CHAR_W = 8,
    parameter int FIFO_DEPTH = 16,
    parameter int RAF_MARGIN = 2,
    parameter bit FIXED_BAUD = 1'b0,
    parameter bit HAS_PKEND = 1'b1,
    parameter bit HAS_FLOW = 1'b1
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [urs_pkg::URS_REG_W-1:0] reg_wdata,
    output logic [urs_pkg::URS_REG_W-1:0] reg_rdata,
    input wire logic rx_char_valid,
    input wire logic [CHAR_W-1:0] rx_char,
    input wire logic rx_break,
    input wire logic rx_frame_err,
    input wire logic rx_parity_err,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [CHAR_W-1:0] tx_data,
    input wire logic tx_shift_busy,
    input wire logic cts_in,
    output logic rts_out,
    output logic tx_break_out,
    output logic [urs_pkg::URS_REG_W-1:0] baud_divider,
    output logic irq
);
    import urs_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);
    localparam logic [AW:0] FULL_LEVEL = (AW+1)'(FIFO_DEPTH);
    localparam logic [AW:0] RAF_LEVEL = (AW+1)'(FIFO_DEPTH - RAF_MARGIN);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic [15:0] widen_char(input logic [CHAR_W-1:0] c);
        widen_char = 16'(c);
    endfunction : widen_char

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire wr_tx = reg_wr && hit(reg_addr, URS_OFF_TX_DATA); // RULE1 RULE3
    wire wr_status = reg_wr && hit(reg_addr, URS_OFF_STATUS); // RULE1
    wire wr_enables = reg_wr && hit(reg_addr, URS_OFF_ENABLES); // RULE1
    wire wr_divider = reg_wr && hit(reg_addr, URS_OFF_DIVIDER) && !FIXED_BAUD; // RULE2
    wire wr_pkend = reg_wr && hit(reg_addr, URS_OFF_PKEND) && HAS_PKEND; // RULE10
    wire rd_rx = reg_rd && hit(reg_addr, URS_OFF_RX_DATA); // RULE1 RULE4

    // ------------------------------------------------------------------
    // FIFOs
    // ------------------------------------------------------------------
    logic rx_in_ready;
    logic rx_out_valid;
    logic [CHAR_W-1:0] rx_out_data;
    logic [AW:0] rx_level;
    logic tx_in_ready;
    logic tx_out_valid;
    logic [CHAR_W-1:0] tx_out_data;
    logic [AW:0] tx_level;
    logic tx_valid_r;
    logic [CHAR_W-1:0] tx_data_r;

    wire rx_pop = rd_rx && rx_out_valid; // RULE4
    wire rx_underrun = rd_rx && !rx_out_valid; // RULE8
    // Full receive FIFO refuses the push, so the newest character is lost
    wire rx_overrun = rx_char_valid && !rx_in_ready; // RULE18
    wire tx_overrun = wr_tx && !tx_in_ready; // RULE17
    wire tx_stage_load = !tx_valid_r || tx_ready;

    urs_fifo #(
        .WIDTH(CHAR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(rx_char_valid),
        .in_ready(rx_in_ready),
        .in_data(rx_char),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_out_data),
        .level(rx_level)
    );

    // Only the low character bits are queued; upper write bits are dropped
    urs_fifo #(
        .WIDTH(CHAR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .in_valid(wr_tx),
        .in_ready(tx_in_ready),
        .in_data(reg_wdata[CHAR_W-1:0]),
        .out_valid(tx_out_valid),
        .out_ready(tx_stage_load),
        .out_data(tx_out_data),
        .level(tx_level)
    ); // RULE3 RULE17

    // ------------------------------------------------------------------
    // Clear-to-send synchroniser and change detect
    // ------------------------------------------------------------------
    logic cts_meta_r;
    logic cts_sync_r;
    logic cts_prev_r;
    // cts_prev_r trails cts_sync_r by one clock, so each edge flags once
    wire cts_change = HAS_FLOW && (cts_sync_r != cts_prev_r); // RULE12

    // ------------------------------------------------------------------
    // Control and sticky state
    // ------------------------------------------------------------------
    logic [15:0] enables_r;
    logic [15:0] divider_r;
    logic [15:0] pkend_char_r;
    logic undr_r;
    logic pkend_r;
    logic ctsc_r;
    logic txov_r;
    logic rxov_r;
    logic lbreak_r;
    logic frame_r;
    logic parity_r;
    logic [15:0] rdata_r;
    logic irq_r;

    // A zero bit in the status write clears the matching sticky flag
    wire [15:0] st_clr = wr_status ? ~reg_wdata : URS_ZERO16; // RULE6 RULE22
    wire pkend_hit = HAS_PKEND && rx_char_valid
        && (widen_char(rx_char) == pkend_char_r); // RULE9

    // Error summary is derived, so clearing its sources clears it too
    wire exc = txov_r || rxov_r || undr_r || lbreak_r || frame_r || parity_r; // RULE13

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    // The output stage holds a character too, so it counts as queued data
    wire tx_idle = !tx_out_valid && !tx_valid_r && !tx_shift_busy; // RULE16
    wire [15:0] status_word = {
        (rx_level >= RAF_LEVEL), // RULE7
        (rx_level == FULL_LEVEL), // RULE7
        undr_r, // RULE8
        pkend_r && HAS_PKEND, // RULE10
        cts_sync_r && HAS_FLOW, // RULE11
        ctsc_r, // RULE12
        1'b0, // RULE19 RULE23
        exc, // RULE13
        rx_out_valid, // RULE14
        tx_in_ready, // RULE15
        tx_idle, // RULE16
        txov_r,
        rxov_r,
        lbreak_r, // RULE19
        frame_r,
        parity_r
    };

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Fill counts show only the low bits, so a full FIFO of power-of-two depth reads as zero
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = URS_ZERO16;
        unique case (reg_addr)
            URS_OFF_RX_DATA: rd_mux = rx_out_valid ? widen_char(rx_out_data) : URS_UNDR_DATA; // RULE4 RULE8
            URS_OFF_TX_DATA: rd_mux = URS_ZERO16; // RULE3
            URS_OFF_STATUS: rd_mux = status_word; // RULE5
            URS_OFF_ENABLES: rd_mux = enables_r;
            URS_OFF_DIVIDER: rd_mux = FIXED_BAUD ? URS_ZERO16 : divider_r; // RULE2
            URS_OFF_PKEND: rd_mux = HAS_PKEND ? pkend_char_r : URS_ZERO16; // RULE10
            URS_OFF_RX_FILL: rd_mux = 16'(rx_level[AW-1:0]);
            URS_OFF_TX_FILL: rd_mux = 16'(tx_level[AW-1:0]);
        endcase
    end

    // Enable bits 11 and 9 drive pins, not interrupts, so they are masked off
    wire irq_nxt = |(status_word & enables_r & URS_CT_IRQ_MASK); // RULE20

    // ------------------------------------------------------------------
    // Flops
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cts_meta_r <= 1'b0;
            cts_sync_r <= 1'b0;
            cts_prev_r <= 1'b0;
        end else begin
            cts_meta_r <= cts_in;
            cts_sync_r <= cts_meta_r;
            cts_prev_r <= cts_sync_r;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            enables_r <= URS_ENABLES_RST; // RULE21
            divider_r <= URS_DIVIDER_RST;
            pkend_char_r <= URS_PKEND_RST;
        end else begin
            if (wr_enables) begin
                enables_r <= reg_wdata;
            end
            if (wr_divider) begin
                divider_r <= reg_wdata; // RULE2
            end
            if (wr_pkend) begin
                pkend_char_r <= reg_wdata; // RULE10
            end
        end
    end

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            undr_r <= 1'b0;
            pkend_r <= 1'b0;
            ctsc_r <= 1'b0;
            txov_r <= 1'b0;
            rxov_r <= 1'b0;
            lbreak_r <= 1'b0;
            frame_r <= 1'b0;
            parity_r <= 1'b0;
        end else begin
            undr_r <= rx_underrun || (undr_r && !st_clr[URS_ST_UNDR]); // RULE8 RULE22
            pkend_r <= pkend_hit || (pkend_r && !st_clr[URS_ST_PKEND]); // RULE9
            ctsc_r <= cts_change || (ctsc_r && !st_clr[URS_ST_CTSC]); // RULE12 RULE6
            txov_r <= tx_overrun || (txov_r && !st_clr[URS_ST_TXOV]); // RULE17 RULE6
            rxov_r <= rx_overrun || (rxov_r && !st_clr[URS_ST_RXOV]); // RULE18 RULE6
            lbreak_r <= rx_break || (lbreak_r && !st_clr[URS_ST_LBREAK]); // RULE19 RULE6
            frame_r <= rx_frame_err || (frame_r && !st_clr[URS_ST_FRAME]); // RULE19 RULE6
            parity_r <= rx_parity_err || (parity_r && !st_clr[URS_ST_PARITY]); // RULE19 RULE6
        end
    end

    // Output stage keeps tx_data off the FIFO array read path
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid_r <= 1'b0;
            tx_data_r <= '0;
        end else if (tx_stage_load) begin
            tx_valid_r <= tx_out_valid;
            tx_data_r <= tx_out_data; // RULE3
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= URS_ZERO16;
            irq_r <= 1'b0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : URS_ZERO16;
            irq_r <= irq_nxt; // RULE20
        end
    end

    assign reg_rdata = rdata_r;
    assign irq = irq_r;
    assign tx_valid = tx_valid_r;
    assign tx_data = tx_data_r;
    assign rts_out = enables_r[URS_CT_RTS] && HAS_FLOW;
    assign tx_break_out = enables_r[URS_CT_TXBREAK];
    assign baud_divider = divider_r;

endmodule : urs_top

`default_nettype wire

/* tb/urs_top_asserts.sv */
/* Port-level assertions for urs_top.
   Assumes the host keeps rx pops and pushes apart at a full or empty FIFO. */
`timescale 1ns/1ps
`default_nettype none
module urs_top_asserts #(
    parameter int CHAR_W = 8,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [urs_pkg::URS_REG_W-1:0] reg_wdata,
    input wire logic [urs_pkg::URS_REG_W-1:0] reg_rdata,
    input wire logic rx_char_valid,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [CHAR_W-1:0] tx_data,
    input wire logic rts_out,
    input wire logic tx_break_out,
    input wire logic irq
);
    import urs_pkg::*;
    localparam int CW = $clog2(FIFO_DEPTH) + 1;
    // ----------------------------------------
    // Shadow of enables and rx occupancy
    // ----------------------------------------
    logic [15:0] en_r;
    logic [CW-1:0] rx_cnt_r;
    wire logic rx_pop = reg_rd && reg_addr == URS_OFF_RX_DATA && rx_cnt_r != 0;
    wire logic rx_push = rx_char_valid && rx_cnt_r < FIFO_DEPTH;
    wire logic en_off = (en_r & URS_CT_IRQ_MASK) == URS_ZERO16;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            en_r <= URS_ENABLES_RST;
            rx_cnt_r <= '0;
        end else begin
            if (reg_wr && reg_addr == URS_OFF_ENABLES)
                en_r <= reg_wdata;
            rx_cnt_r <= rx_cnt_r + CW'(rx_push) - CW'(rx_pop);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_status_rd;
        reg_rd && reg_addr == URS_OFF_STATUS;
    endsequence
    sequence s_empty_pop;
        reg_rd && reg_addr == URS_OFF_RX_DATA && rx_cnt_r == 0;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == URS_ZERO16)
        else $error("read data not zero after idle cycle");
    a_underrun_data: assert property (s_empty_pop |=> reg_rdata == URS_UNDR_DATA)
        else $error("empty receive read returned wrong value");
    a_underrun_flag: assert property (s_empty_pop ##2 s_status_rd |=> reg_rdata[URS_ST_UNDR])
        else $error("underrun flag not set");
    a_exc_summary: assert property (s_status_rd |=> reg_rdata[URS_ST_EXC] ==
        |{reg_rdata[13], reg_rdata[4:0]}) else $error("exception bit disagrees with error flags");
    a_reserved_zero: assert property (s_status_rd |=> !reg_rdata[9])
        else $error("reserved status bit set");
    a_rx_avail: assert property (s_status_rd |=> reg_rdata[URS_ST_RXAV] == ($past(rx_cnt_r) != 0))
        else $error("receive ready flag wrong");
    a_rx_full: assert property (s_status_rd |=> reg_rdata[URS_ST_RX_FULL] == ($past(rx_cnt_r) == FIFO_DEPTH))
        else $error("receive full flag wrong");
    a_irq_masked: assert property (en_off [*2] |-> !irq)
        else $error("interrupt with all enables clear");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("transmit offer dropped before acceptance");
    a_ctrl_pins: assert property ({rts_out, tx_break_out} == {en_r[URS_CT_RTS], en_r[URS_CT_TXBREAK]})
        else $error("control pins differ from enables");
endmodule : urs_top_asserts
`default_nettype wire

/* tb/urs_host_model.sv */
/* Host processor model on the register port of urs_top.
   Assumes the block samples requests on the rising edge; drives at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module urs_host_model (
    input wire logic sys_clk,
    output logic [2:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [urs_pkg::URS_REG_W-1:0] reg_wdata,
    input wire logic [urs_pkg::URS_REG_W-1:0] reg_rdata
);
    import urs_pkg::*;
    initial begin
        reg_addr = 3'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        // Released data shows a changed pattern, never the last value
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
    task automatic ack();
        wr(URS_OFF_STATUS, URS_ZERO16);
    endtask : ack
    // Blind sends exist only to provoke an overrun on purpose
    task automatic tx_send(input logic [15:0] d, input logic blind);
        logic [15:0] st;
        if (!blind) begin
            rd(URS_OFF_STATUS, st);
            if (!st[URS_ST_TXSP])
                return;
        end
        wr(URS_OFF_TX_DATA, d);
    endtask : tx_send
endmodule : urs_host_model
`default_nettype wire

/* tb/testbench.sv */
/* Self-checking bench for urs_top with the default build.
   Assumes the host model above; the shifter side is driven here. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import urs_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] reg_addr;
    logic reg_wr, reg_rd, tx_valid, rts_out, tx_break_out, irq;
    logic [15:0] reg_wdata, reg_rdata, baud_divider;
    logic rx_char_valid = 1'b0;
    logic [7:0] rx_char = 8'h00;
    logic [7:0] tx_data;
    logic rx_break = 1'b0, rx_frame_err = 1'b0, rx_parity_err = 1'b0;
    logic tx_ready = 1'b0, tx_shift_busy = 1'b0, cts_in = 1'b0;
    int err_count = 0;
    int check_count = 0;
    always #2 sys_clk = ~sys_clk;
    urs_top #(.CHAR_W(8), .FIFO_DEPTH(16), .RAF_MARGIN(2)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_break(rx_break),
        .rx_frame_err(rx_frame_err), .rx_parity_err(rx_parity_err), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .tx_shift_busy(tx_shift_busy), .cts_in(cts_in),
        .rts_out(rts_out), .tx_break_out(tx_break_out), .baud_divider(baud_divider), .irq(irq));
    urs_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rd_chk(input string name, input logic [2:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        check(name, d, exp);
    endtask : rd_chk
    task automatic pulse_rx(input logic [7:0] c);
        @(negedge sys_clk);
        rx_char = c;
        rx_char_valid = 1'b1;
        @(negedge sys_clk);
        rx_char_valid = 1'b0;
        rx_char = ~c;
    endtask : pulse_rx
    task automatic stop_test();
        if (err_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_regs();
        rd_chk("enables", URS_OFF_ENABLES, 16'h0000);
        rd_chk("status", URS_OFF_STATUS, 16'h0060);
        rd_chk("status again", URS_OFF_STATUS, 16'h0060);
        host.wr(URS_OFF_DIVIDER, 16'h1234);
        rd_chk("divider", URS_OFF_DIVIDER, 16'h1234);
        check("divider port", baud_divider, 16'h1234);
        host.wr(URS_OFF_PKEND, 16'h0041);
        rd_chk("packet end char", URS_OFF_PKEND, 16'h0041);
        host.wr(URS_OFF_RX_FILL, 16'hFFFF);
        rd_chk("rx fill", URS_OFF_RX_FILL, 16'h0000);
        host.wr(URS_OFF_RX_DATA, 16'hFFFF);
        rd_chk("tx fill", URS_OFF_TX_FILL, 16'h0000);
        host.wr(URS_OFF_ENABLES, 16'h0A00);
        check("ctrl pins", {14'h0000, rts_out, tx_break_out}, 16'h0003);
        rd_chk("enables rw", URS_OFF_ENABLES, 16'h0A00);
        host.wr(URS_OFF_ENABLES, 16'h0000);
    endtask : test_regs
    task automatic test_tx();
        int n;
        for (int i = 0; i < 17; i++)
            host.tx_send(16'hFF50 + 16'(i), 1'b0);
        check("tx head", {8'h00, tx_data}, 16'h0050);
        rd_chk("status tx full", URS_OFF_STATUS, 16'h0000);
        rd_chk("tx fill full", URS_OFF_TX_FILL, 16'h0000);
        host.tx_send(16'h00AA, 1'b1);
        rd_chk("status overrun", URS_OFF_STATUS, 16'h0110);
        tx_ready = 1'b1;
        n = 0;
        for (int k = 0; k < 60 && n < 17; k++) begin
            if (tx_valid === 1'b1) begin
                check("tx order", {8'h00, tx_data}, 16'h0050 + 16'(n));
                n++;
            end
            @(negedge sys_clk);
        end
        tx_ready = 1'b0;
        check("tx count", 16'(n), 16'h0011);
        if (n != 17)
            stop_test();
        tx_shift_busy = 1'b1;
        rd_chk("status shifting", URS_OFF_STATUS, 16'h0150);
        tx_shift_busy = 1'b0;
        rd_chk("status idle", URS_OFF_STATUS, 16'h0170);
        host.ack();
        rd_chk("status ack", URS_OFF_STATUS, 16'h0060);
    endtask : test_tx
    task automatic test_rx();
        for (int i = 0; i < 16; i++) begin
            pulse_rx(i == 5 ? 8'h41 : 8'h30 + 8'(i));
            if (i == 12)
                rd_chk("status below margin", URS_OFF_STATUS, 16'h10E0);
            if (i == 13)
                rd_chk("status at margin", URS_OFF_STATUS, 16'h90E0);
        end
        rd_chk("status rx full", URS_OFF_STATUS, 16'hD0E0);
        rd_chk("rx fill full", URS_OFF_RX_FILL, 16'h0000);
        pulse_rx(8'h7E);
        rd_chk("status rx overrun", URS_OFF_STATUS, 16'hD1E8);
        host.wr(URS_OFF_ENABLES, 16'h0080);
        repeat (2) @(negedge sys_clk);
        check("irq on", {15'h0000, irq}, 16'h0001);
        host.wr(URS_OFF_ENABLES, 16'h0000);
        repeat (2) @(negedge sys_clk);
        check("irq off", {15'h0000, irq}, 16'h0000);
        for (int i = 0; i < 16; i++)
            rd_chk("rx data", URS_OFF_RX_DATA, i == 5 ? 16'h0041 : 16'h0030 + 16'(i));
        rd_chk("rx underrun data", URS_OFF_RX_DATA, 16'h000F);
        rd_chk("status underrun", URS_OFF_STATUS, 16'h3168);
        host.ack();
        rd_chk("status cleared", URS_OFF_STATUS, 16'h0060);
    endtask : test_rx
    task automatic test_errors();
        logic [15:0] exp_st [3] = '{16'h0164, 16'h0166, 16'h0167};
        for (int k = 0; k < 3; k++) begin
            @(negedge sys_clk);
            {rx_parity_err, rx_frame_err, rx_break} = 3'h1 << k;
            @(negedge sys_clk);
            {rx_parity_err, rx_frame_err, rx_break} = 3'h0;
            rd_chk("status error", URS_OFF_STATUS, exp_st[k]);
        end
        host.wr(URS_OFF_ENABLES, 16'h0001);
        repeat (3) @(negedge sys_clk);
        check("irq held", {15'h0000, irq}, 16'h0001);
        host.ack();
        repeat (2) @(negedge sys_clk);
        check("irq acked", {15'h0000, irq}, 16'h0000);
        host.wr(URS_OFF_ENABLES, 16'h0000);
    endtask : test_errors
    task automatic test_cts();
        cts_in = 1'b1;
        repeat (6) @(negedge sys_clk);
        rd_chk("status cts", URS_OFF_STATUS, 16'h0C60);
        host.ack();
        rd_chk("status cts ack", URS_OFF_STATUS, 16'h0860);
    endtask : test_cts
    initial begin
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        test_regs();
        test_tx();
        test_rx();
        test_errors();
        test_cts();
        stop_test();
    end
endmodule : testbench
bind urs_top urs_top_asserts #(.CHAR_W(CHAR_W), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_char_valid(rx_char_valid), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rts_out(rts_out), .tx_break_out(tx_break_out), .irq(irq));
`default_nettype wire
